// *** logic/timer_bank_pkg.sv ***
/*
 * timer_bank_pkg: register offsets, field positions and reset values of the
 * prescaled countdown timer bank.
 * assumes: used by package::name only, never imported.
 */
package timer_bank_pkg;
    localparam int ADDR_W = 8; // internal i/o address width used by the bank
    // register offsets
    localparam logic [7:0] OFF_CTRL_STATUS = 8'hA0;
    localparam logic [7:0] OFF_PRESCALE = 8'hA1;
    localparam logic [7:0] OFF_CONTROL = 8'hA4;
    // time constant offsets, index 0 is subtimer 1 ... index 9 is subtimer 10
    localparam logic [7:0] OFF_TC1 = 8'hA3;
    localparam logic [7:0] OFF_TC2 = 8'hA5;
    localparam logic [7:0] OFF_TC8 = 8'hA6;
    localparam logic [7:0] OFF_TC3 = 8'hA7;
    localparam logic [7:0] OFF_TC9 = 8'hA8;
    localparam logic [7:0] OFF_TC4 = 8'hA9;
    localparam logic [7:0] OFF_TC10 = 8'hAA;
    localparam logic [7:0] OFF_TC5 = 8'hAB;
    localparam logic [7:0] OFF_TC6 = 8'hAD;
    localparam logic [7:0] OFF_TC7 = 8'hAF;
    // field positions
    localparam int CS_CLK_EN_BIT = 0;  // main clock enable, write-only
    localparam int PRE_DIV2_BIT = 0;   // 1 = peripheral clock divided by two
    localparam int CTL_PRIO_LSB = 0;   // two-bit priority field
    localparam int CTL_CASCADE_LSB = 2; // cascade selects for subtimers 2..7
    // reset values
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    localparam logic CTRL_STATUS_CLK_RESET = 1'b0;
    localparam logic PRESCALE_DIV2_RESET = 1'b1;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIME_CONST_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
endpackage

// *** logic/subtimer.sv ***
/*
 * subtimer: one 8-bit reloadable countdown divider.
 * assumes: in_pulse is a one-clock strobe from the bank; time_constant is
 * held by the bank and may change at any time.
 */
`timescale 1ns/1ns
`default_nettype none
module subtimer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_pulse,
    input wire logic [7:0] time_constant,
    output logic out_pulse
);
    // all state in one struct
    typedef struct packed {
        logic [7:0] count; // current count
        logic pulse;       // registered output pulse
    } sub_state_s;

    sub_state_s state;
    sub_state_s next_state;

    // countdown and reload
    always_comb
    begin
        next_state = state;
        next_state.pulse = 1'b0;
        if (in_pulse)
        begin
            if (state.count == 8'h00)
            begin
                // constant picked up only here, so a late write waits for the next reload
                next_state.count = time_constant;
                next_state.pulse = 1'b1; // one clock wide
            end
            else
            begin
                next_state.count = state.count - 8'h01;
            end
        end
    end

    // register the state
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state.count <= timer_bank_pkg::COUNT_RESET;
            state.pulse <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign out_pulse = state.pulse;

    // a pulse only follows an input pulse seen at zero
    pulse_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
        out_pulse |-> $past(in_pulse) && $past(state.count) == 8'h00)
        else $error("output pulse without reload");
    // reload takes the held constant
    reload_value_a: assert property (@(posedge clock) disable iff (sys_rst)
        (in_pulse && state.count == 8'h00) |=> state.count == $past(time_constant))
        else $error("reload value wrong");
    // no input pulse, count holds
    count_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !in_pulse |=> $stable(state.count))
        else $error("count moved without input pulse");
endmodule
`default_nettype wire

// *** logic/timer_bank.sv ***
/*
 * timer_bank: ten 8-bit countdown subtimers on one selectable main clock,
 * with status, interrupt enables, cascade selection and prescale.
 * assumes: a synchronous internal i/o port (address, write strobe, read
 * strobe, byte data); a read strobe lasts one clock per access.
 */
`timescale 1ns/1ns
`default_nettype none
module timer_bank #(
    parameter int NUM_SUB = 10,  // subtimers in the bank
    parameter int NUM_IRQ = 7    // subtimers able to set flags
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic irq_req,
    output logic [1:0] irq_priority,
    output logic [NUM_IRQ-1:0] baud_clock_pulse,
    output logic port_clock_pulse,
    output logic capture_clock_pulse,
    output logic pwm_clock_pulse,
    output logic quadrature_clock_pulse
);
    // the bus decode below is fixed to ten subtimers, seven flagged
    if (NUM_SUB != 10 || NUM_IRQ != 7)
    begin : gen_bad_size
        $error("timer_bank supports only ten subtimers, seven flagged");
    end

    // all bank state
    typedef struct packed {
        logic clk_en;                   // main clock gate
        logic div2;                     // prescale selection
        logic div_phase;                // half-rate toggle
        logic [7:0] control;            // cascade and priority
        logic [7:1] irq_en;             // per-subtimer enables
        logic [7:1] done;               // done flags
        logic [7:0] rdata;              // read data
        logic irq;                      // interrupt request
        logic [NUM_IRQ-1:0] baud;       // baud clock outputs
        logic port_clk;                 // subtimer 1 output
        logic cap_clk;
        logic pwm_clk;
        logic quad_clk;
        logic [NUM_SUB*8-1:0] tc;       // time constants, write-only
    } bank_state_s;

    bank_state_s state;
    bank_state_s next_state;

    logic main_pulse;                   // shared main clock strobe
    logic [NUM_SUB-1:0] sub_in;         // per-subtimer input strobe
    logic [NUM_SUB-1:0] sub_out;        // per-subtimer output strobe
    logic [NUM_SUB-1:0] tc_hit;         // write decode per constant
    logic status_rd;                    // status read this cycle, for the checks

    // main clock: full rate or every other cycle, gated by enable
    always_comb
    begin
        // one strobe for every subtimer, so a prescale change is seen by all
        main_pulse = state.clk_en && (!state.div2 || state.div_phase);
    end

    // offset of each time constant, by subtimer index
    function automatic logic [7:0] tc_offset(input int idx);
        case (idx)
            0: tc_offset = timer_bank_pkg::OFF_TC1;
            1: tc_offset = timer_bank_pkg::OFF_TC2;
            2: tc_offset = timer_bank_pkg::OFF_TC3;
            3: tc_offset = timer_bank_pkg::OFF_TC4;
            4: tc_offset = timer_bank_pkg::OFF_TC5;
            5: tc_offset = timer_bank_pkg::OFF_TC6;
            6: tc_offset = timer_bank_pkg::OFF_TC7;
            7: tc_offset = timer_bank_pkg::OFF_TC8;
            8: tc_offset = timer_bank_pkg::OFF_TC9;
            default: tc_offset = timer_bank_pkg::OFF_TC10;
        endcase
    endfunction

    // one subtimer per channel
    genvar g;
    generate
        for (g = 0; g < NUM_SUB; g++)
        begin : gen_sub
            if (g >= 1 && g <= 6)
            begin : gen_cascade
                // subtimers 2..7 may follow subtimer 1
                assign sub_in[g] = state.control[timer_bank_pkg::CTL_CASCADE_LSB + g - 1]
                    ? (sub_out[0] && state.clk_en) : main_pulse;
            end
            else
            begin : gen_direct
                // subtimer 1 and 8..10 have no cascade input
                assign sub_in[g] = main_pulse;
            end
            assign tc_hit[g] = io_wr && (io_addr == tc_offset(g));
            subtimer u_sub (
                .clock(clock),
                .sys_rst(sys_rst),
                .in_pulse(sub_in[g]),
                .time_constant(state.tc[g*8 +: 8]),
                .out_pulse(sub_out[g])
            );
            // a write to this constant lands next cycle
            tc_write_a: assert property (@(posedge clock) disable iff (sys_rst)
                tc_hit[g] |=> state.tc[g*8 +: 8] == $past(io_wdata))
                else $error("time constant write not stored");
        end
    endgenerate

    // register file, flags and outputs
    always_comb
    begin
        next_state = state;
        next_state.div_phase = state.clk_en ? !state.div_phase : 1'b0;
        next_state.rdata = 8'h00;
        // time constants, loaded on write only
        for (int i = 0; i < NUM_SUB; i++)
        begin
            if (tc_hit[i])
                next_state.tc[i*8 +: 8] = io_wdata;
        end
        if (io_wr)
        begin
            case (io_addr)
                timer_bank_pkg::OFF_CTRL_STATUS:
                begin
                    next_state.irq_en = io_wdata[7:1];
                    next_state.clk_en = io_wdata[timer_bank_pkg::CS_CLK_EN_BIT];
                end
                timer_bank_pkg::OFF_PRESCALE:
                begin
                    // upper bits dropped on purpose
                    next_state.div2 = io_wdata[timer_bank_pkg::PRE_DIV2_BIT];
                end
                timer_bank_pkg::OFF_CONTROL:
                begin
                    next_state.control = io_wdata;
                end
                default:
                begin
                    // constants handled above, others ignored
                end
            endcase
        end
        // status read: return flags, clear only those returned
        if (io_rd && io_addr == timer_bank_pkg::OFF_CTRL_STATUS)
        begin
            next_state.rdata = {state.done, 1'b0}; // enable bit 0 reads as zero
            next_state.done = 7'h00;
        end
        // set wins over read clear, nothing lost
        next_state.done = next_state.done | sub_out[NUM_IRQ-1:0];
        // one shared request, priority 00 masks it
        // priority taken from the value being stored, so the request never
        // stands beside a priority of 00 after a control write
        next_state.irq = |(next_state.done & state.irq_en)
            && (next_state.control[timer_bank_pkg::CTL_PRIO_LSB +: 2] != 2'b00);
        next_state.baud = sub_out[NUM_IRQ-1:0];
        next_state.port_clk = sub_out[0];
        next_state.cap_clk = sub_out[7];
        next_state.pwm_clk = sub_out[8];
        next_state.quad_clk = sub_out[9];
    end

    // register the bank
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state.clk_en <= timer_bank_pkg::CTRL_STATUS_CLK_RESET;
            state.div2 <= timer_bank_pkg::PRESCALE_DIV2_RESET;
            state.div_phase <= 1'b0;
            state.control <= timer_bank_pkg::CONTROL_RESET;
            state.irq_en <= timer_bank_pkg::CTRL_STATUS_RESET[7:1];
            state.done <= 7'h00;
            state.rdata <= 8'h00;
            state.irq <= 1'b0;
            state.baud <= '0;
            state.port_clk <= 1'b0;
            state.cap_clk <= 1'b0;
            state.pwm_clk <= 1'b0;
            state.quad_clk <= 1'b0;
            state.tc <= {NUM_SUB{timer_bank_pkg::TIME_CONST_RESET}};
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign io_rdata = state.rdata;
    assign irq_req = state.irq;
    assign irq_priority = state.control[timer_bank_pkg::CTL_PRIO_LSB +: 2];
    assign baud_clock_pulse = state.baud;
    assign port_clock_pulse = state.port_clk;
    assign capture_clock_pulse = state.cap_clk;
    assign pwm_clock_pulse = state.pwm_clk;
    assign quadrature_clock_pulse = state.quad_clk;

    // status read decode shared by the checks below
    assign status_rd = io_rd && (io_addr == timer_bank_pkg::OFF_CTRL_STATUS);

    // gated clock stops all counting
    clock_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        !state.clk_en |-> sub_in == '0)
        else $error("subtimer counted with main clock off");
    // half rate never strobes two cycles running, unless the selection moved
    half_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
        (state.div2 && main_pulse) ##1 state.div2 |-> !main_pulse)
        else $error("divided clock strobed back to back");
    // half rate strobes again one cycle after a gap
    divide_phase_a: assert property (@(posedge clock) disable iff (sys_rst)
        (state.clk_en && state.div2 && !main_pulse) ##1 (state.clk_en && state.div2)
        |-> main_pulse)
        else $error("divided clock missed a strobe");
    // full rate strobes every enabled cycle
    full_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
        (state.clk_en && !state.div2) |-> main_pulse)
        else $error("full rate clock missed a cycle");
    // first cycle out of reset: half rate, clock off, no enables, no flags
    reset_default_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> state.div2 && !state.clk_en && state.irq_en == 7'h00
        && state.done == 7'h00)
        else $error("reset values wrong");

    // register writes land in the next cycle
    enable_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        (io_wr && io_addr == timer_bank_pkg::OFF_CTRL_STATUS)
        |=> state.irq_en == $past(io_wdata[7:1])
        && state.clk_en == $past(io_wdata[timer_bank_pkg::CS_CLK_EN_BIT]))
        else $error("status write not stored");
    // only the selection bit of a prescale write has any effect
    prescale_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        (io_wr && io_addr == timer_bank_pkg::OFF_PRESCALE)
        |=> state.div2 == $past(io_wdata[timer_bank_pkg::PRE_DIV2_BIT])
        && $stable(state.control) && $stable(state.irq_en) && $stable(state.clk_en))
        else $error("prescale write wrong");
    control_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        (io_wr && io_addr == timer_bank_pkg::OFF_CONTROL) |=> state.control == $past(io_wdata))
        else $error("control write not stored");
    // without a write the settings and constants hold
    reg_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        !io_wr |=> $stable(state.control) && $stable(state.irq_en) && $stable(state.div2)
        && $stable(state.clk_en))
        else $error("setting changed without a write");
    tc_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        !io_wr |=> $stable(state.tc))
        else $error("time constant changed without a write");

    // terminal count sets its flag next cycle
    flag_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        sub_out[0] |=> state.done[1])
        else $error("done flag not set");
    // every flagged subtimer keeps its terminal count, read or not
    flags_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        sub_out[NUM_IRQ-1:0] != '0
        |=> (state.done & $past(sub_out[NUM_IRQ-1:0])) == $past(sub_out[NUM_IRQ-1:0]))
        else $error("a done flag was lost");
    // dedicated subtimers never touch the flags
    flag_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        (sub_out[NUM_IRQ-1:0] == '0 && !status_rd) |=> $stable(state.done))
        else $error("done flags moved without a cause");
    // read returns then clears the flags
    read_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        (io_rd && io_addr == timer_bank_pkg::OFF_CTRL_STATUS && sub_out[6:0] == 7'h00)
        |=> state.done == 7'h00 && io_rdata[7:1] == $past(state.done))
        else $error("status read wrong");
    // a count arriving with the read stays set for the next one
    read_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
        status_rd |=> state.done == $past(sub_out[NUM_IRQ-1:0]))
        else $error("count during read lost");
    status_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        status_rd |=> io_rdata == {$past(state.done), 1'b0})
        else $error("status read data wrong");
    // constants and prescale are write-only, read data idles at zero
    rdata_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
        !status_rd |=> io_rdata == 8'h00)
        else $error("read data outside a status read");

    // request follows enabled flags and priority
    irq_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
        irq_req |-> irq_priority != 2'b00 && (state.done & $past(state.irq_en)) != 7'h00)
        else $error("interrupt without enabled flag");
    prio_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
        irq_priority == 2'b00 |-> !irq_req)
        else $error("request with interrupts disabled");
    irq_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        ((state.done & state.irq_en) != 7'h00 && irq_priority != 2'b00 && !io_wr && !io_rd)
        |=> irq_req)
        else $error("enabled flag raised no request");
    // flags cleared by a read leave no request behind
    read_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
        (status_rd && sub_out[NUM_IRQ-1:0] == '0) |=> !irq_req)
        else $error("request after flags were cleared");

    // cascade input only from subtimer 1
    cascade_src_a: assert property (@(posedge clock) disable iff (sys_rst)
        (state.control[2] && !sub_out[0]) |-> !sub_in[1])
        else $error("cascaded subtimer counted without source");
    cascade_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        (state.control[2] && sub_out[0] && state.clk_en) |-> sub_in[1])
        else $error("cascaded subtimer missed its source");
    // dedicated subtimers never follow subtimer 1
    dedicated_src_a: assert property (@(posedge clock) disable iff (sys_rst)
        sub_in[9:7] == {3{main_pulse}})
        else $error("dedicated subtimer clock wrong");

    // outputs are the subtimer strobes one flop later
    port_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        port_clock_pulse == $past(sub_out[0]))
        else $error("port clock does not follow subtimer 1");
    baud_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        baud_clock_pulse == $past(sub_out[NUM_IRQ-1:0]))
        else $error("baud clocks do not follow subtimers");
    dedicated_out_a: assert property (@(posedge clock) disable iff (sys_rst)
        {quadrature_clock_pulse, pwm_clock_pulse, capture_clock_pulse}
        == $past(sub_out[9:7]))
        else $error("dedicated clock outputs wrong");
endmodule
`default_nettype wire

// *** tb/prescaled_countdown_timer_bank_tb_top.sv ***
/*
 * prescaled_countdown_timer_bank_tb_top: self-checking bench for timer_bank.
 * assumes: timer_bank and timer_bank_pkg from logic/, one 250 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module prescaled_countdown_timer_bank_tb_top;
    logic clock; // 4 ns period
    logic sys_rst; // synchronous, active high
    logic [7:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic irq_req;
    logic [1:0] irq_priority;
    logic [6:0] baud_clock_pulse;
    logic port_clock_pulse;
    logic capture_clock_pulse;
    logic pwm_clock_pulse;
    logic quadrature_clock_pulse;
    logic [9:0] pulses; // bit k-1 is subtimer k
    int mismatches;
    int total_checks;
    int cycles; // hang guard
    logic [31:0] seed; // xorshift state
    logic [7:0] tc [10]; // constants as last written
    logic [7:0] offs [10]; // constant offsets, subtimer order

    assign pulses = {quadrature_clock_pulse, pwm_clock_pulse, capture_clock_pulse,
        baud_clock_pulse};

    timer_bank uut (.clock(clock), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .irq_req(irq_req),
        .irq_priority(irq_priority), .baud_clock_pulse(baud_clock_pulse),
        .port_clock_pulse(port_clock_pulse), .capture_clock_pulse(capture_clock_pulse),
        .pwm_clock_pulse(pwm_clock_pulse), .quadrature_clock_pulse(quadrature_clock_pulse));

    // free-running clock
    initial clock = 1'b0;
    always #2 clock = ~clock;

    // repeatable random source
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected pulse spacing in clocks for subtimer k
    function automatic int exp_period(input int k, input logic [5:0] casc, input int d);
        int p;
        p = d * (tc[k-1] + 1);
        if (k >= 2 && k <= 7 && casc[k-2])
            p = p * (tc[0] + 1); // cascade input is subtimer 1 output
        return p;
    endfunction

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clock);
        #1 io_wr = 1'b0;
    endtask

    // one-cycle read strobe, data looked at in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        #1 io_addr = a;
        io_rd = 1'b1;
        @(posedge clock);
        #1 io_rd = 1'b0;
        chk(io_rdata, exp, "read data");
    endtask

    // clocks until pulse bit b is seen high, bounded
    task automatic count_hi(input int b, output int c);
        c = 0;
        do
        begin
            @(posedge clock);
            #1 c++;
        end while (pulses[b] !== 1'b1 && c < 4000);
    endtask

    // no output pulse at all for n clocks
    task automatic quiet(input int n);
        repeat (n)
        begin
            @(posedge clock);
            #1 chk(pulses, 16'h0000, "pulse while stopped");
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // port clock must be the same pulse train as baud bit 0
    always @(posedge clock)
        if (!sys_rst)
            chk(port_clock_pulse, baud_clock_pulse[0], "port clock");

    // hang guard, far above the expected run length
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            $display("ERROR %0t timeout", $time);
            end_of_test();
        end
    end

    initial
    begin
        logic [31:0] r;
        int c;
        int d;
        logic [5:0] casc;
        io_addr = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        sys_rst = 1'b1;
        seed = 32'hF6F16D45;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        offs = '{timer_bank_pkg::OFF_TC1, timer_bank_pkg::OFF_TC2, timer_bank_pkg::OFF_TC3,
            timer_bank_pkg::OFF_TC4, timer_bank_pkg::OFF_TC5, timer_bank_pkg::OFF_TC6,
            timer_bank_pkg::OFF_TC7, timer_bank_pkg::OFF_TC8, timer_bank_pkg::OFF_TC9,
            timer_bank_pkg::OFF_TC10};
        foreach (tc[i]) tc[i] = 8'h00;
        repeat (16) @(posedge clock);
        #1 sys_rst = 1'b0;
        // reset state, write-only places read back as zero
        chk({irq_req, irq_priority}, 16'h0000, "irq after reset");
        rd(timer_bank_pkg::OFF_CTRL_STATUS, 8'h00);
        rd(timer_bank_pkg::OFF_TC1, 8'h00);
        rd(timer_bank_pkg::OFF_PRESCALE, 8'h00);
        quiet(40);
        $display("test reset done");
        // pulse spacing of every subtimer, random constants and cascade selects
        wr(timer_bank_pkg::OFF_CTRL_STATUS, 8'h01);
        for (int round = 0; round < 3; round++)
        begin
            r = next_rand();
            casc = r[7:2];
            d = (round == 1) ? 1 : 2; // round 0 relies on the reset prescale
            if (round > 0)
                wr(timer_bank_pkg::OFF_PRESCALE, {r[15:9], d == 2});
            wr(timer_bank_pkg::OFF_CONTROL, r[7:0]);
            chk(irq_priority, r[1:0], "priority");
            for (int k = 0; k < 10; k++)
            begin
                r = next_rand();
                tc[k] = (round == 2 && k == 7) ? 8'hFF : {5'h00, r[2:0]}; // top count
                wr(offs[k], tc[k]);
            end
            for (int k = 1; k <= 10; k++)
            begin
                count_hi(k - 1, c);
                count_hi(k - 1, c);
                chk(16'(c), 16'(exp_period(k, casc, d)), "period");
            end
        end
        $display("test periods done");
        // new constant waits for the next reload
        wr(timer_bank_pkg::OFF_PRESCALE, 8'h00);
        wr(timer_bank_pkg::OFF_TC1, 8'h09);
        count_hi(0, c);
        count_hi(0, c);
        wr(timer_bank_pkg::OFF_TC1, 8'h03);
        count_hi(0, c);
        chk(16'(c), 16'h0008, "old constant kept");
        count_hi(0, c);
        chk(16'(c), 16'h0004, "new constant used");
        $display("test reload done");
        // flags, enables, priority and request
        wr(timer_bank_pkg::OFF_CONTROL, 8'h00);
        repeat (400) @(posedge clock);
        wr(timer_bank_pkg::OFF_CTRL_STATUS, 8'h00);
        repeat (4) @(posedge clock);
        quiet(30);
        for (int k = 1; k <= 7; k++)
        begin
            wr(timer_bank_pkg::OFF_CONTROL, 8'(k % 4));
            wr(timer_bank_pkg::OFF_CTRL_STATUS, 8'h01 << k);
            #1 repeat (3) @(posedge clock);
            #1 chk(irq_req, (k % 4) != 0, "request");
        end
        wr(timer_bank_pkg::OFF_CTRL_STATUS, 8'h00);
        repeat (3) @(posedge clock);
        #1 chk(irq_req, 1'b0, "request while disabled");
        wr(timer_bank_pkg::OFF_CONTROL, 8'h01);
        wr(timer_bank_pkg::OFF_CTRL_STATUS, 8'hFE);
        rd(timer_bank_pkg::OFF_CTRL_STATUS, 8'hFE);
        repeat (3) @(posedge clock);
        #1 chk(irq_req, 1'b0, "request after clear");
        rd(timer_bank_pkg::OFF_CTRL_STATUS, 8'h00);
        $display("test status done");
        end_of_test();
    end
endmodule
`default_nettype wire
